// [rtl/fec_flash_eeprom_controller.sv]
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Config writes only within 6 cycles of unlock
// - Enable bit reserves data memory from flash
// - Size field picks partition split
// - Mode bit3 target, bit1 selects width
// - Pattern 1X01 erases 1K program page
// - Standalone erase (1X00) is offered for program flash only
// - Go counts only within four cycles of arm
// - Arm clears itself after four cycles
// - Read result valid two cycles later
// - Read fetches whole 32-bit word
// - No program flash read path
// - CPU held while an operation runs
// - Data-memory writes always erase location first
// - 16-bit mode word address is bits 14:1
// - 16-bit read lands in internal register
// - Pattern 1X10 programs 16-bit word
// - Address bit 0 picks internal byte
module fec_flash_eeprom_controller #(
   parameter int OP_CYCLES = 16
) (
   // Clock and reset
   input  wire  logic                  clock_i,
   input  wire  logic                  sys_rst_i,
   // Register port
   input  wire  logic                  io_wr_i,
   input  wire  logic                  io_rd_i,
   input  wire  logic [5:0]            io_addr_i,
   input  wire  logic [7:0]            io_wdata_i,
   output logic       [7:0]            io_rdata_o,
   // Flash array
   output fec_pkg::fec_flash_req_t     flash_req_o,
   input  wire  logic [31:0]           flash_rdata_i,
   input  wire  logic                  flash_busy_i,
   // System
   output logic                        cpu_hold_o,
   output logic                        ready_irq_o,
   output logic                        data_memory_enable_o,
   output logic [1:0]                  partition_size_select_o,
   output logic [14:0]                 dm_base_o
);
   import fec_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_ERASE = 4'b0010,
      ST_PROG  = 4'b0100,
      ST_DONE  = 4'b1000
   } fec_state_t;

   logic [7:0]  ctl_ff;
   logic [7:0]  cfg_ff;
   logic [14:0] addr_ff;
   logic [15:0] wdat_ff;
   logic [15:0] rdat_ff;
   logic [31:0] rword_ff;
   logic [2:0]  cfg_cnt_ff;
   logic [2:0]  arm_cnt_ff;
   logic [1:0]  rd_cnt_ff;
   logic [15:0] op_cnt_ff;
   fec_state_t  state_ff;
   fec_state_t  nxt_state;
   fec_flash_req_t req_ff;
   logic [3:0]  mode;
   logic        wr_ctl;
   logic        go_req;
   logic        arm_live;
   logic        busy;
   logic [15:0] old_half;

   assign mode     = ctl_ff[7:4];
   assign wr_ctl   = io_wr_i && (io_addr_i == ADDR_NVM_CONTROL);
   assign arm_live = ctl_ff[CTL_ARM] && (arm_cnt_ff != 3'h0);
   assign busy     = (state_ff != ST_IDLE);
   // Half of the last fetched word that a byte write merges into
   assign old_half = addr_ff[1] ? rword_ff[31:16] : rword_ff[15:0];
   // Go accepted only while arm window open and idle
   assign go_req   = wr_ctl && io_wdata_i[CTL_GO] && !ctl_ff[CTL_GO] && arm_live && !busy;

   // ==========================================================
   // Partition configuration with timed unlock
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cfg_ff     <= NVM_PARTITION_CONFIG_RST;
         cfg_cnt_ff <= 3'h0;
      end else if (io_wr_i && (io_addr_i == ADDR_NVM_PARTITION_CONFIG)) begin
         if (io_wdata_i[CFG_UNLOCK]) begin
            cfg_cnt_ff <= CFG_WINDOW_CYC;
         end else if (cfg_cnt_ff != 3'h0) begin
            cfg_ff     <= {1'b0, io_wdata_i[6], 4'h0, io_wdata_i[1:0]};
            cfg_cnt_ff <= 3'h0;
         end
      end else if (cfg_cnt_ff != 3'h0) begin
         cfg_cnt_ff <= cfg_cnt_ff - 3'h1;
      end
   end

   // Data-memory base: flash top minus partition size
   always_comb begin
      data_memory_enable_o    = cfg_ff[CFG_DM_EN];
      partition_size_select_o = cfg_ff[1:0];
      if (!cfg_ff[CFG_DM_EN]) begin
         dm_base_o = 15'h7fff;
      end else begin
         case (cfg_ff[1:0])
            2'b00:   dm_base_o = 15'h7800;
            2'b01:   dm_base_o = 15'h7000;
            2'b10:   dm_base_o = 15'h6000;
            default: dm_base_o = 15'h4000;
         endcase
      end
   end

   // ==========================================================
   // Address and internal data register
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         addr_ff <= 15'h0000;
      end else if (io_wr_i && (io_addr_i == ADDR_ACCESS_ADDRESS_LOW)) begin
         addr_ff[7:0] <= io_wdata_i;
      end else if (io_wr_i && (io_addr_i == ADDR_ACCESS_ADDRESS_HIGH)) begin
         addr_ff[14:8] <= io_wdata_i[6:0];
      end
   end

   // Byte writes land in half chosen by address bit 0
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wdat_ff <= 16'h0000;
      end else if (io_wr_i && (io_addr_i == ADDR_DATA_BYTE_PORT)) begin
         if (addr_ff[0]) begin
            wdat_ff[15:8] <= io_wdata_i;
         end else begin
            wdat_ff[7:0] <= io_wdata_i;
         end
      end else if ((state_ff == ST_DONE) && mode[3] && (mode[1:0] == 2'b11)) begin
         wdat_ff <= 16'h0000;
      end
   end

   // ==========================================================
   // Control register, arm window
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctl_ff     <= NVM_CONTROL_RST;
         arm_cnt_ff <= 3'h0;
      end else begin
         if (wr_ctl) begin
            // Mode frozen while busy so a running phase keeps its kind
            if (!busy) begin
               ctl_ff[7:4] <= io_wdata_i[7:4];
            end
            ctl_ff[CTL_RDY_IE]  <= io_wdata_i[CTL_RDY_IE];
            ctl_ff[CTL_READ_EN] <= io_wdata_i[CTL_READ_EN] && !busy && !io_wdata_i[7];
         end else if (rd_cnt_ff == 2'h1) begin
            ctl_ff[CTL_READ_EN] <= 1'b0;
         end
         // Arm only when go is low, both as held and as written;
         // a go write never re-arms, so the window cannot be stretched
         if (wr_ctl && io_wdata_i[CTL_ARM] && !io_wdata_i[CTL_GO] && !ctl_ff[CTL_GO]) begin
            ctl_ff[CTL_ARM] <= 1'b1;
            arm_cnt_ff      <= ARM_WINDOW_CYC;
         end else if (arm_cnt_ff == 3'h1) begin
            ctl_ff[CTL_ARM] <= 1'b0;
            arm_cnt_ff      <= 3'h0;
         end else if (arm_cnt_ff != 3'h0) begin
            arm_cnt_ff <= arm_cnt_ff - 3'h1;
         end
         // Go set by accepted start, cleared by hardware at finish
         if (go_req) begin
            ctl_ff[CTL_GO] <= 1'b1;
         end else if (state_ff == ST_DONE) begin
            ctl_ff[CTL_GO] <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Data-memory read: two-cycle latency, whole word fetched
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_cnt_ff <= 2'h0;
         rword_ff  <= 32'h0000_0000;
         rdat_ff   <= 16'h0000;
      end else if (wr_ctl && io_wdata_i[CTL_READ_EN] && !busy && !io_wdata_i[7]) begin
         rd_cnt_ff <= READ_LAT_CYC;
      end else if (rd_cnt_ff == 2'h1) begin
         rd_cnt_ff <= 2'h0;
         rword_ff  <= flash_rdata_i;
         rdat_ff   <= addr_ff[1] ? flash_rdata_i[31:16] : flash_rdata_i[15:0];
      end else if (rd_cnt_ff != 2'h0) begin
         rd_cnt_ff <= rd_cnt_ff - 2'h1;
      end
   end

   // Register readback
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         io_rdata_o <= 8'h00;
      end else if (io_rd_i && (io_addr_i == ADDR_NVM_CONTROL)) begin
         io_rdata_o <= ctl_ff;
      end else if (io_rd_i && (io_addr_i == ADDR_NVM_PARTITION_CONFIG)) begin
         io_rdata_o <= cfg_ff;
      end else if (io_rd_i && (io_addr_i == ADDR_ACCESS_ADDRESS_LOW)) begin
         io_rdata_o <= addr_ff[7:0];
      end else if (io_rd_i && (io_addr_i == ADDR_ACCESS_ADDRESS_HIGH)) begin
         io_rdata_o <= {1'b0, addr_ff[14:8]};
      end else if (io_rd_i && (io_addr_i == ADDR_DATA_BYTE_PORT)) begin
         io_rdata_o <= addr_ff[0] ? rdat_ff[15:8] : rdat_ff[7:0];
      end else if (io_rd_i) begin
         io_rdata_o <= 8'h00;
      end
   end

   // ==========================================================
   // Operation sequencer
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            // Leave idle only on an accepted go
            if (go_req) begin
               if (mode[3] && (mode[1:0] == 2'b11)) begin
                  nxt_state = ST_DONE;
               end else if (mode[3] && (mode[1:0] != 2'b10)) begin
                  nxt_state = ST_ERASE;
               end else if (!mode[3]) begin
                  nxt_state = ST_ERASE;
               end else begin
                  nxt_state = ST_PROG;
               end
            end
         end
         ST_ERASE: begin
            if ((op_cnt_ff == 16'h0000) && !flash_busy_i) begin
               nxt_state = mode[3] ? ST_DONE : ST_PROG;
            end
         end
         ST_PROG: begin
            if ((op_cnt_ff == 16'h0000) && !flash_busy_i) begin
               nxt_state = ST_DONE;
            end
         end
         ST_DONE:  nxt_state = ST_IDLE;
         default:  nxt_state = ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Per-phase minimum duration counter
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         op_cnt_ff <= 16'h0000;
      end else if (nxt_state != state_ff) begin
         op_cnt_ff <= 16'(OP_CYCLES);
      end else if (op_cnt_ff != 16'h0000) begin
         op_cnt_ff <= op_cnt_ff - 16'h0001;
      end
   end

   // Flash request; byte writes merge into the fetched word
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         req_ff <= '0;
      end else begin
         req_ff.rd         <= (rd_cnt_ff != 2'h0);
         req_ff.erase      <= (nxt_state == ST_ERASE) && !(mode[3] && mode[0]);
         req_ff.page_erase <= (nxt_state == ST_ERASE) && mode[3] && mode[0];
         req_ff.wr         <= (nxt_state == ST_PROG);
         if (state_ff == ST_IDLE) begin
            req_ff.word_addr <= (mode[3] && !mode[1]) ? {addr_ff[14:10], 9'h000}
                                                      : addr_ff[14:1];
            if (!mode[3] && !mode[1]) begin
               req_ff.wdata <= addr_ff[0] ? {wdat_ff[15:8], old_half[7:0]}
                                          : {old_half[15:8], wdat_ff[7:0]};
            end else begin
               req_ff.wdata <= wdat_ff;
            end
         end
      end
   end

   assign flash_req_o = req_ff;
   assign cpu_hold_o  = busy;
   // Pulse when hardware drops go
   assign ready_irq_o = ctl_ff[CTL_RDY_IE] && (state_ff == ST_DONE);
endmodule : fec_flash_eeprom_controller
`default_nettype wire

// [rtl/fec_pkg.sv]
package fec_pkg;
   // ==========================================================
   // Register map
   localparam logic [5:0] ADDR_DATA_BYTE_PORT      = 6'h20;
   localparam logic [5:0] ADDR_ACCESS_ADDRESS_LOW  = 6'h21;
   localparam logic [5:0] ADDR_ACCESS_ADDRESS_HIGH = 6'h22;
   localparam logic [5:0] ADDR_NVM_CONTROL         = 6'h1f;
   localparam logic [5:0] ADDR_NVM_PARTITION_CONFIG = 6'h36;
   localparam logic [7:0] NVM_CONTROL_RST          = 8'h00;
   localparam logic [7:0] NVM_PARTITION_CONFIG_RST = 8'h00;
   // ==========================================================
   // Control and config field positions
   localparam int CTL_READ_EN   = 0;
   localparam int CTL_GO        = 1;
   localparam int CTL_ARM       = 2;
   localparam int CTL_RDY_IE    = 3;
   localparam int CTL_MODE_LO   = 4;
   localparam int CFG_UNLOCK    = 7;
   localparam int CFG_DM_EN     = 6;
   // ==========================================================
   // Timing (system cycles)
   localparam logic [2:0] CFG_WINDOW_CYC = 3'h6;
   localparam logic [2:0] ARM_WINDOW_CYC = 3'h4;
   localparam logic [1:0] READ_LAT_CYC   = 2'h2;
   // ==========================================================
   // Flash side request carrier
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic        erase;
      logic        page_erase;
      logic [13:0] word_addr;
      logic [15:0] wdata;
   } fec_flash_req_t;
endpackage : fec_pkg

// [bench/fec_flash_eeprom_controller_properties.sv]
`timescale 1ns/100ps
`default_nettype none
// ========================================
// Port checker for the flash controller
module fec_flash_eeprom_controller_properties
   import fec_pkg::*;
#(
   parameter int OP_CYCLES = 16
) (
   // Clock and reset
   input wire logic                    clock_i,
   input wire logic                    sys_rst_i,
   // Register port
   input wire logic                    io_wr_i,
   input wire logic [5:0]              io_addr_i,
   input wire logic [7:0]              io_wdata_i,
   // Watched outputs
   input wire fec_pkg::fec_flash_req_t flash_req_o,
   input wire logic                    cpu_hold_o,
   input wire logic                    ready_irq_o,
   input wire logic                    data_memory_enable_o,
   input wire logic [1:0]              partition_size_select_o
);
   logic [3:0] arm_age_ff;
   logic [3:0] unl_age_ff;
   logic       ctl_wr;
   logic       cfg_wr;
   logic       arm_wr;
   logic       go_wr;
   // Decode of control and config writes
   assign ctl_wr = io_wr_i && (io_addr_i == ADDR_NVM_CONTROL);
   assign cfg_wr = io_wr_i && (io_addr_i == ADDR_NVM_PARTITION_CONFIG);
   assign arm_wr = ctl_wr && io_wdata_i[CTL_ARM] && !io_wdata_i[CTL_GO] && !cpu_hold_o;
   assign go_wr  = ctl_wr && io_wdata_i[CTL_GO] && !io_wdata_i[CTL_READ_EN] && !cpu_hold_o;
   // Cycles since the last idle arm write, saturating
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) arm_age_ff <= 4'hf;
      else if (arm_wr) arm_age_ff <= 4'h1;
      else if (arm_age_ff != 4'hf) arm_age_ff <= arm_age_ff + 4'h1;
   end
   // Cycles since the last config unlock, saturating; a config write inside the window sets it back to 4'hf
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) unl_age_ff <= 4'hf;
      else if (cfg_wr && io_wdata_i[CFG_UNLOCK]) unl_age_ff <= 4'h1;
      else if (cfg_wr && unl_age_ff < 4'h7) unl_age_ff <= 4'hf;
      else if (unl_age_ff != 4'hf) unl_age_ff <= unl_age_ff + 4'h1;
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   AST_CFG_LOCKED: assert property (cfg_wr && !io_wdata_i[CFG_UNLOCK] && unl_age_ff > 4'h7
      |=> $stable(data_memory_enable_o) && $stable(partition_size_select_o))
      else $error("config changed while locked");
   AST_CFG_TAKEN: assert property (cfg_wr && !io_wdata_i[CFG_UNLOCK] && unl_age_ff < 4'h6
      |=> partition_size_select_o == $past(io_wdata_i[1:0])
      && data_memory_enable_o == $past(io_wdata_i[CFG_DM_EN]))
      else $error("config write in window not taken");
   AST_GO_ACCEPT: assert property (go_wr && arm_age_ff < 4'h5 |-> ##[1:2] cpu_hold_o)
      else $error("armed go did not start");
   AST_GO_REFUSED: assert property (go_wr && arm_age_ff > 4'h4 |=> !cpu_hold_o [*2])
      else $error("unarmed go started");
   AST_IRQ_END: assert property (ready_irq_o |-> cpu_hold_o ##1 !cpu_hold_o)
      else $error("ready pulse not at end of operation");
   AST_IRQ_PULSE: assert property (ready_irq_o |=> !ready_irq_o)
      else $error("ready pulse too long");
   AST_OP_HOLDS: assert property (flash_req_o.wr || flash_req_o.erase || flash_req_o.page_erase
      |-> cpu_hold_o || $past(cpu_hold_o))
      else $error("flash operation without cpu hold");
   AST_HOLD_ENDS: assert property ($rose(cpu_hold_o) |-> ##[1:200] !cpu_hold_o)
      else $error("cpu hold never released");
   // Main scenarios
   COV_GO: cover property (go_wr && arm_age_ff < 4'h4);
   COV_CFG: cover property (cfg_wr && unl_age_ff < 4'h6);
   COV_IRQ: cover property (ready_irq_o);
endmodule : fec_flash_eeprom_controller_properties
bind fec_flash_eeprom_controller fec_flash_eeprom_controller_properties #(
   .OP_CYCLES(OP_CYCLES)
) u_props (
   .clock_i(clock_i),
   .sys_rst_i(sys_rst_i),
   .io_wr_i(io_wr_i),
   .io_addr_i(io_addr_i),
   .io_wdata_i(io_wdata_i),
   .flash_req_o(flash_req_o),
   .cpu_hold_o(cpu_hold_o),
   .ready_irq_o(ready_irq_o),
   .data_memory_enable_o(data_memory_enable_o),
   .partition_size_select_o(partition_size_select_o)
);
`default_nettype wire

// [bench/fec_flash_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ========================================
// Flash array model, prompt or slow
module fec_flash_model
   import fec_pkg::*;
#(
   parameter logic [31:0] WORD = 32'h9c41_27d8
) (
   // Clock, reset, pace
   input wire logic                    clock_i,
   input wire logic                    sys_rst_i,
   input wire logic                    slow_i,
   // Array side
   input wire fec_pkg::fec_flash_req_t flash_req_i,
   output logic [31:0]                 flash_rdata_o,
   output logic                        flash_busy_o
);
   logic       rd_q_ff;
   logic [2:0] op_q_ff;
   logic [1:0] busy_ff;
   logic [2:0] op_kind;
   logic       op_now;
   // Whole word while a read is asked and one cycle after, inverted garbage otherwise
   assign flash_rdata_o = (flash_req_i.rd || rd_q_ff) ? WORD : ~WORD;
   assign op_kind = {flash_req_i.wr, flash_req_i.erase, flash_req_i.page_erase};
   assign op_now = (op_kind != 3'h0);
   assign flash_busy_o = (busy_ff != 2'h0);
   // Slow array stretches each new erase or program phase
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_q_ff <= 1'b0;
         op_q_ff <= 3'h0;
         busy_ff <= 2'h0;
      end else begin
         rd_q_ff <= flash_req_i.rd;
         op_q_ff <= op_kind;
         if (slow_i && op_now && (op_kind != op_q_ff)) busy_ff <= 2'h3;
         else if (busy_ff != 2'h0) busy_ff <= busy_ff - 2'h1;
      end
   end
endmodule : fec_flash_model
`default_nettype wire

// [bench/fec_flash_eeprom_controller_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fails++; \
$display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module fec_flash_eeprom_controller_bench;
   import fec_pkg::*;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic io_wr_i = 1'b0;
   logic io_rd_i = 1'b0;
   logic [5:0] io_addr_i = 6'h00;
   logic [7:0] io_wdata_i = 8'h00;
   logic [7:0] io_rdata_o;
   fec_flash_req_t flash_req_o;
   logic [31:0] flash_rdata_i;
   logic flash_busy_i;
   logic cpu_hold_o;
   logic ready_irq_o;
   logic data_memory_enable_o;
   logic [1:0] partition_size_select_o;
   logic slow = 1'b0;
   logic er_first;
   logic [13:0] wr_adr;
   logic [13:0] pe_adr;
   logic [15:0] wr_dat;
   logic [7:0] v;
   int fails = 0;
   int n_compared = 0;
   int n_wr, n_er, n_pe, n_rd, n_irq, n_hold;
   // ========================================
   // Clock, design and array model
   always #20 clock_i = ~clock_i;
   fec_flash_eeprom_controller #(.OP_CYCLES(2)) uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i),
      .io_rdata_o(io_rdata_o), .flash_req_o(flash_req_o), .flash_rdata_i(flash_rdata_i),
      .flash_busy_i(flash_busy_i), .cpu_hold_o(cpu_hold_o), .ready_irq_o(ready_irq_o),
      .data_memory_enable_o(data_memory_enable_o),
      .partition_size_select_o(partition_size_select_o), .dm_base_o());
   fec_flash_model u_flash (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .slow_i(slow),
      .flash_req_i(flash_req_o), .flash_rdata_o(flash_rdata_i), .flash_busy_o(flash_busy_i));
   // Tally of array requests seen
   always @(posedge clock_i) begin
      if (flash_req_o.wr && n_wr == 0) er_first = (n_er != 0);
      if (flash_req_o.wr) wr_adr = flash_req_o.word_addr;
      if (flash_req_o.wr) wr_dat = flash_req_o.wdata;
      if (flash_req_o.page_erase) pe_adr = flash_req_o.word_addr;
      n_wr += flash_req_o.wr;
      n_er += flash_req_o.erase;
      n_pe += flash_req_o.page_erase;
      n_rd += flash_req_o.rd;
      n_irq += ready_irq_o;
      n_hold += cpu_hold_o;
   end
   // ========================================
   // Register port tasks
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge clock_i);
      io_addr_i = a;
      io_wdata_i = d;
      io_wr_i = 1'b1;
      @(negedge clock_i);
      io_wr_i = 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a);
      @(negedge clock_i);
      io_addr_i = a;
      io_rd_i = 1'b1;
      @(negedge clock_i);
      io_rd_i = 1'b0;
      v = io_rdata_o;
   endtask : rd
   // Arm and go with ready interrupt on, then wait for release
   task automatic run(input logic [3:0] m);
      {n_wr, n_er, n_pe, n_rd, n_irq, n_hold} = '0;
      wr(ADDR_NVM_CONTROL, {m, 4'hc});
      wr(ADDR_NVM_CONTROL, {m, 4'he});
      @(negedge clock_i);
      for (int i = 0; i < 300 && cpu_hold_o !== 1'b0; i++) @(negedge clock_i);
      repeat (2) @(negedge clock_i);
      `CHK("hold seen", 1'b1, n_hold != 0)
      `CHK("ready irq", 1, n_irq)
      `CHK("hold released", 1'b0, cpu_hold_o)
      rd(ADDR_NVM_CONTROL);
      `CHK("go clear", 1'b0, v[CTL_GO])
   endtask : run
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   initial begin
      #200000;
      fails++;
      wrap_up();
   end
   // ========================================
   // Test sequence
   initial begin
      repeat (8) @(negedge clock_i);
      sys_rst_i = 1'b0;
      rd(ADDR_NVM_CONTROL);
      `CHK("ctl reset", NVM_CONTROL_RST, v)
      rd(ADDR_NVM_PARTITION_CONFIG);
      `CHK("cfg reset", NVM_PARTITION_CONFIG_RST, v)
      rd(6'h3a);
      `CHK("unmapped", 8'h00, v)
      wr(ADDR_NVM_PARTITION_CONFIG, 8'h43);
      `CHK("locked cfg", 1'b0, data_memory_enable_o)
      for (int s = 0; s < 4; s++) begin
         wr(ADDR_NVM_PARTITION_CONFIG, 8'h80);
         wr(ADDR_NVM_PARTITION_CONFIG, {6'h10, s[1:0]});
         `CHK("size", s[1:0], partition_size_select_o)
         `CHK("dm enable", 1'b1, data_memory_enable_o)
         rd(ADDR_NVM_PARTITION_CONFIG);
         `CHK("cfg read", {6'h10, s[1:0]}, v)
      end
      wr(ADDR_NVM_PARTITION_CONFIG, 8'h80);
      repeat (8) @(negedge clock_i);
      wr(ADDR_NVM_PARTITION_CONFIG, 8'h00);
      `CHK("late cfg", 1'b1, data_memory_enable_o)
      wr(ADDR_NVM_CONTROL, 8'h04);
      repeat (6) @(negedge clock_i);
      rd(ADDR_NVM_CONTROL);
      `CHK("arm clear", 1'b0, v[CTL_ARM])
      wr(ADDR_NVM_CONTROL, 8'h06);
      @(negedge clock_i);
      `CHK("late go", 1'b0, cpu_hold_o)
      wr(ADDR_ACCESS_ADDRESS_LOW, 8'h06);
      wr(ADDR_ACCESS_ADDRESS_HIGH, 8'h00);
      wr(ADDR_NVM_CONTROL, 8'h21);
      repeat (3) @(negedge clock_i);
      rd(ADDR_DATA_BYTE_PORT);
      `CHK("rd16 low", 8'h41, v)
      wr(ADDR_ACCESS_ADDRESS_LOW, 8'h07);
      rd(ADDR_DATA_BYTE_PORT);
      `CHK("rd16 high", 8'h9c, v)
      wr(ADDR_ACCESS_ADDRESS_LOW, 8'h05);
      wr(ADDR_NVM_CONTROL, 8'h01);
      repeat (3) @(negedge clock_i);
      rd(ADDR_DATA_BYTE_PORT);
      `CHK("rd8", 8'h27, v)
      wr(ADDR_DATA_BYTE_PORT, 8'h5a);
      slow = 1'b1;
      run(4'h0);
      slow = 1'b0;
      `CHK("erase first", 1'b1, er_first)
      `CHK("byte merge", 16'h5ad8, wr_dat)
      wr(ADDR_ACCESS_ADDRESS_LOW, 8'h06);
      run(4'h2);
      `CHK("word addr", 14'h0003, wr_adr)
      wr(ADDR_ACCESS_ADDRESS_LOW, 8'h00);
      wr(ADDR_DATA_BYTE_PORT, 8'h34);
      wr(ADDR_ACCESS_ADDRESS_LOW, 8'h01);
      wr(ADDR_DATA_BYTE_PORT, 8'h12);
      wr(ADDR_ACCESS_ADDRESS_LOW, 8'h00);
      wr(ADDR_ACCESS_ADDRESS_HIGH, 8'h01);
      run(4'ha);
      `CHK("prog data", 16'h1234, wr_dat)
      `CHK("prog addr", 14'h0080, wr_adr)
      wr(ADDR_ACCESS_ADDRESS_HIGH, 8'h2c);
      run(4'hd);
      `CHK("page addr", 5'h0b, pe_adr[13:9])
      `CHK("page no write", 0, n_wr)
      run(4'h8);
      `CHK("erase only", 1'b1, n_er != 0 && n_wr == 0)
      run(4'hb);
      `CHK("reset no op", 0, n_er + n_wr + n_pe)
      wr(ADDR_NVM_CONTROL, 8'h81);
      repeat (4) @(negedge clock_i);
      `CHK("no prog read", 0, n_rd)
      wrap_up();
   end
endmodule : fec_flash_eeprom_controller_bench
`default_nettype wire
